// file: bench/event_channel_properties.sv
`timescale 1ns/10ps
module event_channel_properties
   import event_chan_pkg::*;
#(
   parameter int EVW = EV_W
) (
   input wire logic              clk,         // Clock
   input wire logic              reset,       // Reset
   input wire logic              bus_req,     // Request
   input wire logic              bus_wr,      // Write
   input wire logic [ADDR_W-1:0] bus_addr,    // Address
   input wire logic [DATA_W-1:0] bus_wdata,   // Write data
   input wire logic [DATA_W-1:0] bus_rdata,   // Read data
   input wire logic              bus_ack,     // Ack
   input wire logic              bus_err,     // Error
   input wire logic [EVW-1:0]    event_in,    // Events
   input wire logic              dma_done,    // DMA done
   input wire logic              dma_req,     // DMA request
   input wire logic              hw_trigger,  // Trigger
   input wire logic              irq_req,     // Interrupt
   input wire logic [EVW-1:0]    done_out     // Done pulses
);
   logic       lock_r;
   logic       ddb_r;
   logic [1:0] type_r;
   logic       ctrl_wr;
   logic       cfg_wr;
   assign ctrl_wr = bus_req && bus_wr && bus_addr == OFS_CTRL;
   assign cfg_wr = bus_req && bus_wr && (bus_addr == OFS_INSEL || bus_addr == OFS_TERM);
   // Shadow of control fields, lock kept sticky
   always_ff @(posedge clk) begin
      if (reset) begin
         lock_r <= 1'b0;
         ddb_r <= 1'b0;
         type_r <= TYPE_OFF;
      end else if (ctrl_wr) begin
         lock_r <= lock_r | bus_wdata[CTRL_LOCK];
         ddb_r <= bus_wdata[CTRL_DDB];
         type_r <= bus_wdata[1:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   chk_locked_write_err: assert property (lock_r && cfg_wr |=> bus_ack && bus_err)
      else $error("locked config write not refused");
   chk_open_write_ok: assert property (!lock_r && cfg_wr |=> bus_ack && !bus_err)
      else $error("unlocked config write refused");
   chk_lock_stays: assert property (lock_r && bus_req && !bus_wr && bus_addr == OFS_CTRL
      |=> bus_rdata[CTRL_LOCK]) else $error("lock bit lost");
   chk_ddb_silent: assert property (ddb_r && $past(ddb_r) && $past(ddb_r, 2)
      |-> done_out == '0) else $error("done sent while broadcast disabled");
   chk_off_quiet: assert property (type_r == TYPE_OFF && $past(type_r) == TYPE_OFF
      && $past(type_r, 2) == TYPE_OFF |-> !(dma_req || hw_trigger || irq_req))
      else $error("request from disabled channel");
   chk_one_role: assert property ($onehot0({dma_req, hw_trigger, irq_req}))
      else $error("more than one request kind");
   chk_trig_pulse: assert property ($rose(hw_trigger) |=> !hw_trigger)
      else $error("trigger longer than one cycle");
   chk_dma_release: assert property (dma_req && dma_done |-> ##[1:2] !dma_req)
      else $error("DMA request not released");
   chk_irq_holds: assert property (irq_req && !bus_req && !$past(bus_req) |=> irq_req)
      else $error("interrupt dropped without clear");
   chk_sel_reserved: assert property (bus_req && !bus_wr && bus_addr == OFS_INSEL
      |=> (bus_rdata & ~INSEL_MASK) == '0) else $error("reserved select bits set");
endmodule
bind event_channel event_channel_properties #(.EVW(EVW)) u_event_channel_properties (
   .clk(clk), .reset(reset), .bus_req(bus_req), .bus_wr(bus_wr), .bus_addr(bus_addr),
   .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err),
   .event_in(event_in), .dma_done(dma_done), .dma_req(dma_req), .hw_trigger(hw_trigger),
   .irq_req(irq_req), .done_out(done_out));

// file: bench/event_env.sv
`timescale 1ns/10ps
module event_env
   import event_chan_pkg::*;
(
   input  wire logic            clk,       // Clock
   input  wire logic            reset,     // Reset
   input  wire logic [EV_W-1:0] src,       // Source request levels
   input  wire logic [1:0]      lat,       // DMA answer delay
   input  wire logic [EV_W-1:0] done_out,  // Done pulses
   input  wire logic            dma_req,   // DMA request
   output logic      [EV_W-1:0] event_in,  // Event lines
   output logic                 dma_done   // DMA completion
);
   logic [EV_W-1:0] served_r;
   logic [2:0]      wait_r;
   always_ff @(posedge clk) begin
      if (reset) begin
         served_r <= '0;
      end else begin
         served_r <= (served_r | done_out) & src;
      end
   end
   assign event_in = src & ~served_r;
   always_ff @(posedge clk) begin
      if (reset || !dma_req) begin
         wait_r <= 3'h0;
         dma_done <= 1'b0;
      end else begin
         wait_r <= wait_r + 3'h1;
         dma_done <= (wait_r == {1'b0, lat});
      end
   end
endmodule

// file: bench/tb_event_channel.sv
`timescale 1ns/10ps
module tb_event_channel;
   import event_chan_pkg::*;
   logic              clk, reset, bus_req, bus_wr, bus_ack, bus_err;
   logic              dma_done, dma_req, hw_trigger, irq_req;
   logic [ADDR_W-1:0] bus_addr;
   logic [DATA_W-1:0] bus_wdata, bus_rdata, rd, s, t;
   logic [EV_W-1:0]   event_in, done_out, src, dn;
   logic [1:0]        lat;
   int                n_fail, checks_done, trg, t_trg, t_dn;
   event_channel u_event_channel (.clk(clk), .reset(reset), .bus_req(bus_req),
      .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .bus_ack(bus_ack), .bus_err(bus_err), .event_in(event_in), .dma_done(dma_done),
      .dma_req(dma_req), .hw_trigger(hw_trigger), .irq_req(irq_req), .done_out(done_out));
   event_env u_event_env (.clk(clk), .reset(reset), .src(src), .lat(lat),
      .done_out(done_out), .dma_req(dma_req), .event_in(event_in), .dma_done(dma_done));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One access, raised a falling edge after the call so back-to-back calls never
   // lower and raise the request in one time step; answer seen at the next falling edge
   task automatic acc(input logic wr, input logic [8:0] a, input logic [31:0] d, input logic e);
      @(negedge clk);
      bus_req = 1'b1;
      bus_wr = wr;
      bus_addr = a;
      bus_wdata = d;
      @(negedge clk);
      bus_req = 1'b0;
      rd = bus_rdata;
      check("ack err", {bus_ack, bus_err}, {1'b1, e});
   endtask
   task automatic run(input int n);
      dn = '0;
      trg = 0;
      t_trg = 0;
      t_dn = 0;
      for (int i = 1; i <= n; i++) begin
         @(negedge clk);
         dn |= done_out;
         if (hw_trigger === 1'b1) begin
            trg++;
            t_trg = i;
         end
         if (done_out !== '0 && t_dn == 0) begin
            t_dn = i;
         end
      end
   endtask
   function automatic logic sop(input logic [31:0] sl, input logic [31:0] tm,
                                input logic [15:0] e);
      logic [3:0] v;
      logic [1:0] c;
      logic       p;
      logic       r;
      r = 1'b0;
      for (int j = 0; j < 4; j++) v[j] = e[sl[24-8*j +: 4]];
      for (int k = 0; k < 4; k++) begin
         p = 1'b1;
         for (int j = 0; j < 4; j++) begin
            c = tm[30-8*k-2*j +: 2];
            p &= (c[0] & v[j]) | (c[1] & ~v[j]);
         end
         r |= p;
      end
      return r;
   endfunction
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      {reset, bus_req, bus_wr, bus_addr, bus_wdata, src, lat} = '0;
      reset = 1'b1;
      n_fail = 0;
      checks_done = 0;
      void'($urandom(66));
      repeat (8) @(negedge clk);
      reset = 1'b0;
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, (i == 0) ? OFS_DATA : (i == 1) ? OFS_CTRL : (i == 2) ? OFS_INSEL : OFS_TERM,
             32'h0, 1'b0);
         check("reset value", rd, REG_RESET);
      end
      acc(1'b0, 9'h008, 32'h0, 1'b1);
      check("unmapped", rd, 32'h0);
      for (int n = 0; n < 12; n++) begin
         s = $urandom;
         t = (n == 0) ? 32'h0 : (n == 1) ? 32'hFFFFFFFF : $urandom;
         src = 16'($urandom);
         acc(1'b1, OFS_CTRL, 32'h0, 1'b0);
         acc(1'b1, OFS_INSEL, s, 1'b0);
         acc(1'b1, OFS_TERM, t, 1'b0);
         acc(1'b0, OFS_INSEL, 32'h0, 1'b0);
         check("select", rd, s & INSEL_MASK);
         acc(1'b1, OFS_CTRL, 32'h03, 1'b0);
         run(6);
         check("sop", irq_req, sop(s, t, src));
      end
      src = '0;
      acc(1'b1, OFS_CTRL, 32'h0, 1'b0);
      acc(1'b1, OFS_INSEL, 32'h05000000, 1'b0);
      acc(1'b1, OFS_TERM, 32'h7F000000, 1'b0);
      for (int m = 0; m < 4; m++) begin
         src = '0;
         acc(1'b1, OFS_CTRL, (m == 2) ? 32'h0A : (m == 3) ? 32'h06 : 32'h02, 1'b0);
         run(2);
         src = 16'h0020;
         run(10);
         check("trigger", trg, 1);
         check("done", dn, (m == 2) ? 16'h0 : 16'h0020);
         if (m != 2) check("done lag", t_dn - t_trg, 1);
      end
      src = '0;
      run(3);
      src = 16'h0020;
      run(10);
      check("one shot", trg, 0);
      acc(1'b0, OFS_DATA, 32'h0, 1'b0);
      check("state", rd[6:4], FSMC_OSHOLD);
      acc(1'b1, OFS_DATA, 32'h60, 1'b0);
      acc(1'b0, OFS_DATA, 32'h0, 1'b0);
      check("soft reset", rd[6:4], FSMC_WFEVT);
      for (int l = 0; l < 4; l += 3) begin
         lat = 2'(l);
         src = '0;
         acc(1'b1, OFS_CTRL, 32'h01, 1'b0);
         run(2);
         src = 16'h0020;
         run(12);
         check("dma done", dn, 16'h0020);
         check("dma req", dma_req, 1'b0);
      end
      src = '0;
      acc(1'b1, OFS_CTRL, 32'h03, 1'b0);
      run(2);
      src = 16'h0020;
      run(8);
      check("irq up", {irq_req, dn}, {1'b1, 16'h0});
      acc(1'b1, OFS_DATA, 32'h80, 1'b0);
      run(4);
      check("irq clear", {irq_req, dn}, {1'b0, 16'h0020});
      for (int d = 0; d < 2; d++) begin
         src = '0;
         acc(1'b1, OFS_CTRL, d ? 32'h08 : 32'h0, 1'b0);
         run(2);
         src = 16'h0020;
         run(3);
         acc(1'b1, OFS_DATA, 32'h20, 1'b0);
         // Forced done pulses alongside the write's ack
         check("forced done", done_out, d ? 16'h0 : 16'h0020);
         acc(1'b0, OFS_DATA, 32'h0, 1'b0);
         check("capture", rd[3:0], 4'h1);
      end
      acc(1'b1, OFS_CTRL, 32'h80, 1'b0);
      acc(1'b1, OFS_INSEL, 32'h0F0F0F0F, 1'b1);
      acc(1'b1, OFS_TERM, 32'h0, 1'b1);
      acc(1'b0, OFS_INSEL, 32'h0, 1'b0);
      check("locked select", rd, 32'h05000000);
      acc(1'b1, OFS_CTRL, 32'h0, 1'b0);
      acc(1'b0, OFS_CTRL, 32'h0, 1'b0);
      check("lock bit", rd[7], 1'b1);
      complete_run();
   end
endmodule

// file: core/event_channel.sv
`timescale 1ns/10ps
// Overview of operation
// - Lock bit stays set once written until hardware reset.
// - Locked: config register writes end in error, contents unchanged.
// - Done broadcast goes to selected inputs unless broadcast disable is set.
// - Broadcast disable also suppresses the forced done on disabled channel.
// - DMA channel done comes from the DMA completion input.
// - Trigger channel done in first cycle after entering assert.
// - Interrupt channel done the cycle after data write clearing output.
// - One-shot enable: fire once; clear: rearm and fire repeatedly.
// - Type 00 off, 01 DMA, 10 trigger, 11 interrupt.
// - Four 4-bit select fields pick inputs A, B, C, D.
// - Unused or disabled inputs have selection logic gated off.
// - Output is OR of four products of configured inputs.
// - Each product term uses eight configuration bits, two per input.
// - Encoding: 00 zero, 01 pass, 10 complement, 11 one.
// - Term 0 input A at bits 31:30, then B, C, D, terms 1-3.
// - Control write disabling or changing low four bits soft-resets machine.
module event_channel
   import event_chan_pkg::*;
#(
   parameter int EVW = EV_W
) (
   input  wire logic                clk,         // System clock
   input  wire logic                reset,       // Synchronous reset
   input  wire logic                bus_req,     // Access request, one cycle
   input  wire logic                bus_wr,      // Write when high
   input  wire logic [ADDR_W-1:0]   bus_addr,    // Byte address
   input  wire logic [DATA_W-1:0]   bus_wdata,   // Write data, all 32 bits used by term register, select keeps bits 0x0F0F0F0F
   output logic      [DATA_W-1:0]   bus_rdata,   // Read data
   output logic                     bus_ack,     // Access done pulse
   output logic                     bus_err,     // Error with ack
   input  wire logic [EVW-1:0]      event_in,    // Asynchronous event inputs
   input  wire logic                dma_done,    // DMA completion, same clock
   output logic                     dma_req,     // DMA request
   output logic                     hw_trigger,  // Hardware trigger
   output logic                     irq_req,     // Interrupt request
   output logic      [EVW-1:0]      done_out     // Done broadcast pulse
);
   generate
      if (EVW < 1 || EVW > (1 << SEL_W)) begin : g_bad_evw
         $error("event_channel: bad EVW");
      end
   endgenerate

   logic [EVW-1:0]  ev_meta_r;
   logic [EVW-1:0]  ev_sync_r;
   logic [31:0]     insel_r;
   logic [31:0]     terms_r;
   logic            lock_r;
   logic            ddb_r;
   logic            ose_r;
   logic [1:0]      type_r;
   logic            evout_r;
   logic [INS-1:0]  cap_r;
   chan_state_t     state_r;
   chan_state_t     state_nxt;
   logic [INS-1:0]  sel_in;
   logic            raw_out;
   logic            wr_data;
   logic            wr_ctrl;
   logic            wr_cfg;
   logic            soft_rst;
   logic            force_cap;
   logic            irq_ack;
   logic            done_evt;

   always_ff @(posedge clk) begin
      if (reset) begin
         ev_meta_r <= '0;
         ev_sync_r <= '0;
      end else begin
         ev_meta_r <= event_in;
         ev_sync_r <= ev_meta_r;
      end
   end

   sop_eval #(.EVW(EVW)) u_eval (
      .events  (ev_sync_r),
      .insel   (insel_r),
      .terms   (terms_r),
      .chan_on (type_r != TYPE_OFF),
      .sel_in  (sel_in),
      .raw_out (raw_out)
   );

   // Low bit of the select field of input i, order A, B, C, D
   function automatic int sel_lo(input int i);
      sel_lo = (i == 0) ? INSEL_A_LO : (i == 1) ? INSEL_B_LO : (i == 2) ? INSEL_C_LO : INSEL_D_LO;
   endfunction

   function automatic logic [2:0] state_code(input chan_state_t s);
      unique case (s)
         ST_IDLE:   state_code = FSMC_IDLE;
         ST_WFEVT:  state_code = FSMC_WFEVT;
         ST_ASSERT: state_code = FSMC_ASSERT;
         ST_DONE:   state_code = FSMC_DONE;
         ST_WFCLR:  state_code = FSMC_WFCLR;
         ST_OSHOLD: state_code = FSMC_OSHOLD;
      endcase
   endfunction

   assign wr_data  = bus_req && bus_wr && (bus_addr == OFS_DATA);
   assign wr_ctrl  = bus_req && bus_wr && (bus_addr == OFS_CTRL);
   assign wr_cfg   = bus_req && bus_wr && ((bus_addr == OFS_INSEL) || (bus_addr == OFS_TERM));
   assign soft_rst = (wr_ctrl && ((bus_wdata[CTRL_TYPE_LO +: 2] == TYPE_OFF)
                     || (bus_wdata[CTRL_SOFT_W-1:0] != {ddb_r, ose_r, type_r})))
                     || (wr_data && bus_wdata[DATA_FSM_LO +: FSM_W] == FSMW_SOFTRST);
   assign force_cap = wr_data && (type_r == TYPE_OFF)
                      && (bus_wdata[DATA_FSM_LO +: FSM_W] == FSMW_CAPTURE);
   // software write of one acknowledges interrupt
   assign irq_ack  = wr_data && bus_wdata[DATA_EVOUT] && (type_r == TYPE_IRQ);

   always_comb begin
      unique case (type_r)
         TYPE_DMA:  done_evt = dma_done;
         TYPE_TRIG: done_evt = 1'b1;
         TYPE_IRQ:  done_evt = irq_ack;
         default:   done_evt = 1'b0;
      endcase
   end

   // Register bus: answer one cycle after the request
   always_ff @(posedge clk) begin
      if (reset) begin
         bus_ack   <= 1'b0;
         bus_err   <= 1'b0;
         bus_rdata <= '0;
      end else begin
         bus_ack   <= bus_req;
         bus_err   <= 1'b0;
         bus_rdata <= '0;
         if (bus_req) begin
            unique case (bus_addr)
               OFS_DATA:  bus_rdata <= {24'h000000, evout_r, state_code(state_r), cap_r};
               OFS_CTRL:  bus_rdata <= {24'h000000, lock_r, 3'h0, ddb_r, ose_r, type_r};
               OFS_INSEL: bus_rdata <= insel_r;
               OFS_TERM:  bus_rdata <= terms_r;
               default:   bus_err   <= 1'b1;
            endcase
            if (wr_cfg && lock_r) begin
               bus_err <= 1'b1;
            end
         end
      end
   end

   // Configuration registers
   always_ff @(posedge clk) begin
      if (reset) begin
         insel_r <= REG_RESET;
         terms_r <= REG_RESET;
      end else if (wr_cfg && !lock_r) begin
         if (bus_addr == OFS_TERM) begin
            terms_r <= bus_wdata;
         end else begin
            insel_r <= bus_wdata & INSEL_MASK;
         end
      end
   end

   // Control register
   always_ff @(posedge clk) begin
      if (reset) begin
         lock_r <= 1'b0;
         ddb_r  <= 1'b0;
         ose_r  <= 1'b0;
         type_r <= TYPE_OFF;
      end else if (wr_ctrl) begin
         lock_r <= lock_r | bus_wdata[CTRL_LOCK];
         ddb_r  <= bus_wdata[CTRL_DDB];
         ose_r  <= bus_wdata[CTRL_OSE];
         type_r <= bus_wdata[CTRL_TYPE_LO +: 2];
      end
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:   if (type_r != TYPE_OFF) state_nxt = ST_WFEVT;
         ST_WFEVT:  if (raw_out) state_nxt = ST_ASSERT;
         ST_ASSERT: if (done_evt) state_nxt = ST_DONE;
         ST_DONE:   state_nxt = ose_r ? ST_OSHOLD : ST_WFCLR;
         ST_WFCLR:  if ((cap_r & sel_in) == '0) state_nxt = ST_WFEVT;
         ST_OSHOLD: state_nxt = ST_OSHOLD;
      endcase
      if (type_r == TYPE_OFF) begin
         state_nxt = ST_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || soft_rst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Captured inputs and event output flag
   always_ff @(posedge clk) begin
      if (reset || soft_rst) begin
         cap_r   <= '0;
         evout_r <= 1'b0;
      end else begin
         if (force_cap) begin
            // Capture bypasses gating so a disabled channel still samples
            for (int i = 0; i < INS; i++) begin
               cap_r[i] <= ev_sync_r[insel_r[sel_lo(i) +: SEL_W]];
            end
         end else if (state_r == ST_WFEVT && raw_out) begin
            cap_r <= sel_in;
         end else if (state_r == ST_WFCLR) begin
            cap_r <= cap_r & sel_in;
         end
         if (state_r == ST_WFEVT && raw_out) begin
            evout_r <= 1'b1;
         end else if (state_r == ST_ASSERT && done_evt) begin
            evout_r <= 1'b0;
         end
      end
   end

   // Request outputs and done broadcast
   always_ff @(posedge clk) begin
      if (reset) begin
         dma_req    <= 1'b0;
         hw_trigger <= 1'b0;
         irq_req    <= 1'b0;
         done_out   <= '0;
      end else begin
         dma_req    <= evout_r && (type_r == TYPE_DMA);
         hw_trigger <= evout_r && (type_r == TYPE_TRIG);
         irq_req    <= evout_r && (type_r == TYPE_IRQ);
         done_out   <= '0;
         if (!ddb_r && state_r == ST_DONE) begin
            for (int i = 0; i < INS; i++) begin
               if (cap_r[i]) begin
                  done_out[insel_r[sel_lo(i) +: SEL_W]] <= 1'b1;
               end
            end
         end
         if (!ddb_r && force_cap) begin
            for (int i = 0; i < INS; i++) begin
               if (ev_sync_r[insel_r[sel_lo(i) +: SEL_W]]) begin
                  done_out[insel_r[sel_lo(i) +: SEL_W]] <= 1'b1;
               end
            end
         end
      end
   end
endmodule

// file: core/sop_eval.sv
`timescale 1ns/10ps
module sop_eval
   import event_chan_pkg::*;
#(
   parameter int EVW = EV_W
) (
   input  wire logic [EVW-1:0]    events,     // Synchronised event vector
   input  wire logic [31:0]       insel,      // Input select register
   input  wire logic [31:0]       terms,      // Boolean term register
   input  wire logic              chan_on,    // Channel type not disabled
   output logic      [INS-1:0]    sel_in,     // Selected inputs {D,C,B,A}
   output logic                   raw_out     // Sum of products
);
   localparam int SEL_LO [INS] = '{INSEL_A_LO, INSEL_B_LO, INSEL_C_LO, INSEL_D_LO};

   generate
      if (EVW > (1 << SEL_W)) begin : g_bad_evw
         $error("sop_eval: event vector wider than select");
      end
   endgenerate

   function automatic logic [1:0] cfg_of(input logic [31:0] t, input int term, input int inp);
      cfg_of = t[31 - 8*term - 2*inp -: 2];
   endfunction

   function automatic logic lit(input logic [1:0] c, input logic v);
      lit = (c[0] & v) | (c[1] & ~v);
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < INS; gi++) begin : g_sel
         logic used;
         logic [SEL_W-1:0] idx;
         always_comb begin
            used = 1'b0;
            for (int t = 0; t < TERMS; t++) begin
               used = used | (cfg_of(terms, t, gi) == CFG_PASS) | (cfg_of(terms, t, gi) == CFG_INV);
            end
            idx = insel[SEL_LO[gi] +: SEL_W];
         end
         assign sel_in[gi] = (used && chan_on) ? events[idx] : 1'b0;
      end
   endgenerate

   always_comb begin
      logic p;
      p       = 1'b0;
      raw_out = 1'b0;
      for (int t = 0; t < TERMS; t++) begin
         p = 1'b1;
         for (int i = 0; i < INS; i++) begin
            p = p & lit(cfg_of(terms, t, i), sel_in[i]);
         end
         raw_out = raw_out | p;
      end
   end
endmodule

// file: include/event_chan_pkg.sv
package event_chan_pkg;
   localparam int          ADDR_W        = 9;
   localparam int          DATA_W        = 32;
   localparam int          EV_W          = 16;
   localparam int          SEL_W         = 4;
   localparam int          TERMS         = 4;
   localparam int          INS           = 4;
   // Register byte offsets
   localparam logic [8:0]  OFS_DATA      = 9'h000;
   localparam logic [8:0]  OFS_CTRL      = 9'h080;
   localparam logic [8:0]  OFS_INSEL     = 9'h100;
   localparam logic [8:0]  OFS_TERM      = 9'h104;
   // Control field positions
   localparam int          CTRL_LOCK     = 7;
   localparam int          CTRL_DDB      = 3;
   localparam int          CTRL_OSE      = 2;
   localparam int          CTRL_TYPE_LO  = 0;
   localparam int          CTRL_SOFT_W   = 4;
   // Data field positions
   localparam int          DATA_EVOUT    = 7;
   localparam int          DATA_FSM_LO   = 4;
   localparam int          FSM_W         = 3;
   // Input select field low bits: A, B, C, D
   localparam int          INSEL_A_LO    = 24;
   localparam int          INSEL_B_LO    = 16;
   localparam int          INSEL_C_LO    = 8;
   localparam int          INSEL_D_LO    = 0;
   localparam logic [31:0] INSEL_MASK    = 32'h0F0F0F0F;
   localparam logic [31:0] REG_RESET     = 32'h00000000;
   // Per-input boolean encoding
   localparam logic [1:0]  CFG_ZERO      = 2'h0;
   localparam logic [1:0]  CFG_PASS      = 2'h1;
   localparam logic [1:0]  CFG_INV       = 2'h2;
   localparam logic [1:0]  CFG_ONE       = 2'h3;
   // Channel types
   localparam logic [1:0]  TYPE_OFF      = 2'h0;
   localparam logic [1:0]  TYPE_DMA      = 2'h1;
   localparam logic [1:0]  TYPE_TRIG     = 2'h2;
   localparam logic [1:0]  TYPE_IRQ      = 2'h3;
   // State readback codes and special write codes
   localparam logic [2:0]  FSMC_IDLE     = 3'h0;
   localparam logic [2:0]  FSMC_WFEVT    = 3'h1;
   localparam logic [2:0]  FSMC_ASSERT   = 3'h3;
   localparam logic [2:0]  FSMC_DONE     = 3'h7;
   localparam logic [2:0]  FSMC_WFCLR    = 3'h5;
   localparam logic [2:0]  FSMC_OSHOLD   = 3'h4;
   localparam logic [2:0]  FSMW_CAPTURE  = 3'h2;
   localparam logic [2:0]  FSMW_SOFTRST  = 3'h6;

   typedef enum logic [2:0] {
      ST_IDLE, ST_WFEVT, ST_ASSERT, ST_DONE, ST_WFCLR, ST_OSHOLD
   } chan_state_t;
endpackage
